/* File: design/output_compare_pwm_unit.sv */
// Purpose: output compare unit with APB registers driving one compare pin
// Assumes: timer counts and rollover pulses arrive synchronous to REF_CLK
// Notes: zero-wait APB slave, answer registered in the setup cycle
//
// Functional notes
// - unit runs only while enable bit set
// - idle_stop halts unit during device idle
// - wide select compares 32 bits, else 16
// - fault_status set by hardware, cleared by disable or by a control write that restarts the mode
// - fault_status reads zero outside mode 111
// - timebase_select picks timebase_b, else timebase_a
// - mode 111 PWM with fault input enabled
// - mode 110 PWM with fault input ignored
// - mode 101 starts low, continuous pulses
// - mode 100 starts low, one pulse
// - mode 011 compare event toggles pin
// - mode 010 starts high, event drives low
// - mode 001 starts low, event drives high
// - mode 000 disables compare function
// - unimplemented control bits read zero
`timescale 1ns/10ps
`include "output_compare_cfg.svh"
module output_compare_pwm_unit (
	input wire logic REF_CLK, // 125 MHz clock
	input wire logic RESET, // async reset, active high
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb enable
	input wire logic PWRITE, // apb direction
	input wire logic [`OC_ADDR_W-1:0] PADDR, // apb byte address
	input wire logic [31:0] PWDATA, // apb write data
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	input wire logic [31:0] TIMEBASE_A_COUNT, // timebase_a count
	input wire logic [31:0] TIMEBASE_B_COUNT, // timebase_b count
	input wire logic TIMEBASE_A_ROLL, // timebase_a period pulse
	input wire logic TIMEBASE_B_ROLL, // timebase_b period pulse
	input wire logic IDLE_MODE, // device is in idle
	input wire logic FAULT_N, // fault input, active low
	output logic COMPARE_OUTPUT_PIN // compare output pin
);
	compare_if cmp ();

	logic on_reg;
	logic on_next;
	logic idle_stop_reg;
	logic idle_stop_next;
	logic wide_reg;
	logic wide_next;
	logic tsel_reg;
	logic tsel_next;
	logic [2:0] mode_reg;
	logic [2:0] mode_next;
	logic [31:0] primary_reg;
	logic [31:0] primary_next;
	logic [31:0] secondary_reg;
	logic [31:0] secondary_next;

	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;

	logic reinit_reg;
	logic reinit_next;
	output_compare_pkg::oc_state_t state_reg;
	output_compare_pkg::oc_state_t state_next;
	logic pin_reg;
	logic pin_next;
	logic fault_reg;
	logic fault_next;
	logic [31:0] duty_reg;
	logic [31:0] duty_next;

	logic setup;
	logic wr;
	logic [31:0] ctrl_view;
	logic [31:0] read_mux;
	logic pwm_mode;
	logic rollover;
	logic halted;
	logic disabled;
	output_compare_pkg::reg_sel_t sel_setup;
	output_compare_pkg::reg_sel_t sel_access;

	function automatic output_compare_pkg::reg_sel_t decode(input logic [`OC_ADDR_W-1:0] a);
		case (a)
			`OC_CTRL_OFS: decode = output_compare_pkg::SEL_CTRL;
			`OC_PRIMARY_OFS: decode = output_compare_pkg::SEL_PRIMARY;
			`OC_SECONDARY_OFS: decode = output_compare_pkg::SEL_SECONDARY;
			default: decode = output_compare_pkg::SEL_NONE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// match detector
	assign cmp.clk = REF_CLK;
	assign cmp.rst = RESET;
	assign cmp.count = tsel_reg ? TIMEBASE_B_COUNT : TIMEBASE_A_COUNT;
	assign cmp.first_value = primary_reg;
	// in PWM the end point is the latched duty, not the live register
	assign cmp.second_value = pwm_mode ? duty_reg : secondary_reg;
	assign cmp.wide = wide_reg;

	compare_match compare_match_inst (
		.cmp(cmp)
	);

	////////////////////////////////////////////////////////////////////////////
	// register bus
	always_comb begin
		ctrl_view = 32'h0000_0000;
		ctrl_view[`OC_ON_BIT] = on_reg;
		ctrl_view[`OC_IDLE_STOP_BIT] = idle_stop_reg;
		ctrl_view[`OC_WIDE_BIT] = wide_reg;
		ctrl_view[`OC_FAULT_BIT] = fault_reg & (mode_reg == `OC_MODE_PWM_FAULT);
		ctrl_view[`OC_TSEL_BIT] = tsel_reg;
		ctrl_view[`OC_MODE_HI:`OC_MODE_LO] = mode_reg;
	end

	always_comb begin
		setup = PSEL & ~PENABLE;
		sel_setup = decode(PADDR);
		sel_access = decode(PADDR);
		wr = PSEL & PENABLE & pready_reg & PWRITE;
		case (sel_setup)
			output_compare_pkg::SEL_CTRL: read_mux = ctrl_view;
			output_compare_pkg::SEL_PRIMARY: read_mux = primary_reg;
			output_compare_pkg::SEL_SECONDARY: read_mux = secondary_reg;
			default: read_mux = 32'h0000_0000;
		endcase
		pready_next = setup;
		pslverr_next = setup & (sel_setup == output_compare_pkg::SEL_NONE);
		prdata_next = (setup & ~PWRITE) ? read_mux : 32'h0000_0000;

		on_next = on_reg;
		idle_stop_next = idle_stop_reg;
		wide_next = wide_reg;
		tsel_next = tsel_reg;
		mode_next = mode_reg;
		primary_next = primary_reg;
		secondary_next = secondary_reg;
		reinit_next = 1'b0;
		if (wr) begin
			case (sel_access)
				output_compare_pkg::SEL_CTRL: begin
					on_next = PWDATA[`OC_ON_BIT];
					idle_stop_next = PWDATA[`OC_IDLE_STOP_BIT];
					wide_next = PWDATA[`OC_WIDE_BIT];
					tsel_next = PWDATA[`OC_TSEL_BIT];
					mode_next = PWDATA[`OC_MODE_HI:`OC_MODE_LO];
					// fault bit is not written here; rewriting the fault mode restarts it
					reinit_next = (PWDATA[`OC_MODE_HI:`OC_MODE_LO] != mode_reg)
						| (PWDATA[`OC_MODE_HI:`OC_MODE_LO] == `OC_MODE_PWM_FAULT)
						| (PWDATA[`OC_ON_BIT] & ~on_reg);
				end
				output_compare_pkg::SEL_PRIMARY: primary_next = PWDATA;
				output_compare_pkg::SEL_SECONDARY: secondary_next = PWDATA;
				default: reinit_next = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// compare engine
	always_comb begin
		pwm_mode = (mode_reg == `OC_MODE_PWM) | (mode_reg == `OC_MODE_PWM_FAULT);
		rollover = tsel_reg ? TIMEBASE_B_ROLL : TIMEBASE_A_ROLL;
		disabled = ~on_reg | (mode_reg == `OC_MODE_OFF);
		halted = idle_stop_reg & IDLE_MODE;
		state_next = state_reg;
		pin_next = pin_reg;
		fault_next = fault_reg;
		duty_next = duty_reg;
		if (disabled) begin
			state_next = output_compare_pkg::ST_OFF;
			pin_next = 1'b0;
			fault_next = 1'b0;
		end else if (halted) begin
			// frozen: pin and sequence keep their place until idle ends
			state_next = state_reg;
		end else if (state_reg == output_compare_pkg::ST_OFF || reinit_reg) begin
			state_next = output_compare_pkg::ST_ARMED;
			pin_next = (mode_reg == `OC_MODE_SET_LOW);
			fault_next = 1'b0;
			duty_next = secondary_reg;
		end else begin
			case (mode_reg)
				`OC_MODE_SET_HIGH: begin
					if (cmp.first_hit) begin
						pin_next = 1'b1;
					end
				end
				`OC_MODE_SET_LOW: begin
					if (cmp.first_hit) begin
						pin_next = 1'b0;
					end
				end
				`OC_MODE_TOGGLE: begin
					if (cmp.first_hit) begin
						pin_next = ~pin_reg;
					end
				end
				`OC_MODE_ONE_PULSE, `OC_MODE_PULSES: begin
					case (state_reg)
						output_compare_pkg::ST_ARMED: begin
							if (cmp.first_hit) begin
								pin_next = 1'b1;
								state_next = output_compare_pkg::ST_PULSE;
							end
						end
						output_compare_pkg::ST_PULSE: begin
							if (cmp.second_hit) begin
								pin_next = 1'b0;
								// single pulse parks; continuous rearms for the next period
								state_next = (mode_reg == `OC_MODE_PULSES)
									? output_compare_pkg::ST_ARMED
									: output_compare_pkg::ST_DONE;
							end
						end
						default: pin_next = 1'b0;
					endcase
				end
				`OC_MODE_PWM, `OC_MODE_PWM_FAULT: begin
					if (rollover) begin
						pin_next = 1'b1;
						duty_next = secondary_reg;
					end else if (cmp.second_hit) begin
						pin_next = 1'b0;
					end
				end
				default: pin_next = 1'b0;
			endcase
		end
		// the event wins over the re-init clear in the same cycle, but not over the disable clear
		if (~disabled & ~halted & (mode_reg == `OC_MODE_PWM_FAULT) & ~FAULT_N) begin
			fault_next = 1'b1;
		end
		if (~disabled & (mode_reg == `OC_MODE_PWM_FAULT) & fault_next) begin
			pin_next = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			on_reg <= 1'b0;
			idle_stop_reg <= 1'b0;
			wide_reg <= 1'b0;
			tsel_reg <= 1'b0;
			mode_reg <= `OC_MODE_OFF;
			primary_reg <= `OC_VALUE_RST;
			secondary_reg <= `OC_VALUE_RST;
			prdata_reg <= `OC_CTRL_RST;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			reinit_reg <= 1'b0;
		end else begin
			on_reg <= on_next;
			idle_stop_reg <= idle_stop_next;
			wide_reg <= wide_next;
			tsel_reg <= tsel_next;
			mode_reg <= mode_next;
			primary_reg <= primary_next;
			secondary_reg <= secondary_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			reinit_reg <= reinit_next;
		end
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state_reg <= output_compare_pkg::ST_OFF;
			pin_reg <= 1'b0;
			fault_reg <= 1'b0;
			duty_reg <= `OC_VALUE_RST;
		end else begin
			state_reg <= state_next;
			pin_reg <= pin_next;
			fault_reg <= fault_next;
			duty_reg <= duty_next;
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign COMPARE_OUTPUT_PIN = pin_reg;
endmodule

/* File: common/output_compare_cfg.svh */
// Purpose: offsets, field positions, reset values and mode codes of the compare unit
// Assumes: 32-bit register bus, one aligned word per register
// Notes: definitions only
`ifndef OUTPUT_COMPARE_CFG_SVH
`define OUTPUT_COMPARE_CFG_SVH

`define OC_ADDR_W 12
`define OC_CTRL_OFS 12'h000
`define OC_PRIMARY_OFS 12'h004
`define OC_SECONDARY_OFS 12'h008

`define OC_ON_BIT 15
`define OC_IDLE_STOP_BIT 13
`define OC_WIDE_BIT 5
`define OC_FAULT_BIT 4
`define OC_TSEL_BIT 3
`define OC_MODE_HI 2
`define OC_MODE_LO 0

`define OC_CTRL_RST 32'h0000_0000
`define OC_VALUE_RST 32'h0000_0000
`define OC_NARROW_MASK 32'h0000_ffff

`define OC_MODE_OFF 3'h0
`define OC_MODE_SET_HIGH 3'h1
`define OC_MODE_SET_LOW 3'h2
`define OC_MODE_TOGGLE 3'h3
`define OC_MODE_ONE_PULSE 3'h4
`define OC_MODE_PULSES 3'h5
`define OC_MODE_PWM 3'h6
`define OC_MODE_PWM_FAULT 3'h7

`endif

/* File: common/output_compare_pkg.sv */
// Purpose: shared types of the compare unit
// Assumes: constants live in output_compare_cfg.svh
// Notes: types only
package output_compare_pkg;
	typedef enum logic [1:0] {
		SEL_CTRL,
		SEL_PRIMARY,
		SEL_SECONDARY,
		SEL_NONE
	} reg_sel_t;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_ARMED,
		ST_PULSE,
		ST_DONE
	} oc_state_t;
endpackage

/* File: common/compare_if.sv */
// Purpose: carries count and compare values to the match detector and events back
// Assumes: one clock domain
// Notes: hits are one-cycle pulses
`timescale 1ns/10ps
interface compare_if;
	logic clk;
	logic rst;
	logic [31:0] count;
	logic [31:0] first_value;
	logic [31:0] second_value;
	logic wide;
	logic first_hit;
	logic second_hit;

	modport matcher (
		input clk,
		input rst,
		input count,
		input first_value,
		input second_value,
		input wide,
		output first_hit,
		output second_hit
	);

	modport owner (
		output clk,
		output rst,
		output count,
		output first_value,
		output second_value,
		output wide,
		input first_hit,
		input second_hit
	);
endinterface

/* File: design/compare_match.sv */
// Purpose: turns equality of count and compare values into one-cycle events
// Assumes: count is synchronous to clk
// Notes: narrow mode compares the low 16 bits only
`timescale 1ns/10ps
`include "output_compare_cfg.svh"
module compare_match (
	compare_if.matcher cmp // count in, events out
);
	logic eq_first;
	logic eq_second;
	logic first_seen_reg;
	logic first_seen_next;
	logic second_seen_reg;
	logic second_seen_next;

	function automatic logic [31:0] fit(input logic [31:0] v, input logic w);
		fit = w ? v : (v & `OC_NARROW_MASK);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		eq_first = fit(cmp.count, cmp.wide) == fit(cmp.first_value, cmp.wide);
		eq_second = fit(cmp.count, cmp.wide) == fit(cmp.second_value, cmp.wide);
		first_seen_next = eq_first;
		second_seen_next = eq_second;
		// a timer parked on the value must not fire again every cycle
		cmp.first_hit = eq_first & ~first_seen_reg;
		cmp.second_hit = eq_second & ~second_seen_reg;
	end

	always_ff @(posedge cmp.clk or posedge cmp.rst) begin
		if (cmp.rst) begin
			first_seen_reg <= 1'b0;
			second_seen_reg <= 1'b0;
		end else begin
			first_seen_reg <= first_seen_next;
			second_seen_reg <= second_seen_next;
		end
	end
endmodule

/* File: bench/pin_load.sv */
// Purpose: external load on the compare pin
// Assumes: the pin is a push-pull output
// Notes: counts rising edges the load sees
`timescale 1ns/10ps
module pin_load (
	input wire logic clk, // sampling clock
	input wire logic pin, // compare output pin
	output int rises // rising edges so far
);
	logic last;
	initial rises = 0;
	initial last = 1'b0;
	always @(posedge clk) begin
		if (pin === 1'b1 && last !== 1'b1) begin
			rises <= rises + 1;
		end
		last <= pin;
	end
endmodule

/* File: bench/output_compare_pwm_unit_assertions.sv */
// Purpose: port checker of the compare unit
// Assumes: one clock domain, reset active high
// Notes: ctl shadows the last control write
`timescale 1ns/10ps
`include "output_compare_cfg.svh"
module compare_unit_checker (
	input wire logic REF_CLK, // clock
	input wire logic RESET, // reset
	input wire logic PSEL, // select
	input wire logic PENABLE, // enable
	input wire logic PWRITE, // direction
	input wire logic [`OC_ADDR_W-1:0] PADDR, // address
	input wire logic [31:0] PWDATA, // write data
	input wire logic [31:0] PRDATA, // read data
	input wire logic PREADY, // ready
	input wire logic PSLVERR, // error
	input wire logic TIMEBASE_A_ROLL, // roll a
	input wire logic TIMEBASE_B_ROLL, // roll b
	input wire logic IDLE_MODE, // idle
	input wire logic FAULT_N, // fault
	input wire logic COMPARE_OUTPUT_PIN // pin
);
	logic [31:0] ctl;
	logic [1:0] quiet;
	logic wr, rd, run;
	assign wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == `OC_CTRL_OFS;
	assign rd = PREADY && !PWRITE && PADDR == `OC_CTRL_OFS;
	// re-init follows a control write, so the pin is judged only once it settles
	assign run = ctl[15] && quiet == 2'h3 && !(IDLE_MODE && ctl[13]);
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			ctl <= 32'h0;
			quiet <= 2'h0;
		end else if (wr) begin
			ctl <= PWDATA;
			quiet <= 2'h0;
		end else if (quiet != 2'h3) begin
			quiet <= quiet + 2'h1;
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
////////////////////////////////////////
	property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
	a_ready: assert property (p_ready) else $error("ready missing");
	property p_err; PREADY && PADDR > `OC_SECONDARY_OFS |-> PSLVERR && PRDATA == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_rsvd; rd |-> PRDATA[31:16] == 16'h0 && !PRDATA[14] && PRDATA[12:6] == 7'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_fmode; rd && PRDATA[2:0] != 3'h7 |-> !PRDATA[4]; endproperty
	a_fmode: assert property (p_fmode) else $error("fault shown");
	// disable wins over the idle freeze, so idle does not excuse a high pin here
	property p_off; !ctl[15] || ctl[2:0] == 3'h0 |=> !COMPARE_OUTPUT_PIN; endproperty
	a_off: assert property (p_off) else $error("pin high while off");
	property p_hold1; run && ctl[2:0] == 3'h1 && COMPARE_OUTPUT_PIN |=> COMPARE_OUTPUT_PIN; endproperty
	a_hold1: assert property (p_hold1) else $error("pin fell");
	property p_hold2; run && ctl[2:0] == 3'h2 && !COMPARE_OUTPUT_PIN |=> !COMPARE_OUTPUT_PIN; endproperty
	a_hold2: assert property (p_hold2) else $error("pin rose");
	property p_idle;
		ctl[15] && ctl[13] && IDLE_MODE && $past(IDLE_MODE) && quiet == 2'h3
			|=> $stable(COMPARE_OUTPUT_PIN);
	endproperty
	a_idle: assert property (p_idle) else $error("pin moved in idle");
	property p_fault; (run && ctl[2:0] == 3'h7 && !FAULT_N) [*4] |-> !COMPARE_OUTPUT_PIN; endproperty
	a_fault: assert property (p_fault) else $error("pin high in fault");
	property p_roll;
		run && ctl[2:0] == 3'h6 && (ctl[3] ? TIMEBASE_B_ROLL : TIMEBASE_A_ROLL)
			|=> COMPARE_OUTPUT_PIN;
	endproperty
	a_roll: assert property (p_roll) else $error("no high at rollover");
	c_err: cover property (PREADY && PSLVERR);
	c_fault: cover property (rd && PRDATA[4]);
	c_idle: cover property (ctl[13] && IDLE_MODE && quiet == 2'h3);
endmodule
bind output_compare_pwm_unit compare_unit_checker compare_unit_checker_inst (.REF_CLK,
	.RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
	.TIMEBASE_A_ROLL, .TIMEBASE_B_ROLL, .IDLE_MODE, .FAULT_N, .COMPARE_OUTPUT_PIN);

/* File: bench/output_compare_pwm_unit_tb_top.sv */
// Purpose: self-checking bench of the compare unit
// Assumes: APB answers in the access cycle
// Notes: timebase_a period 40, timebase_b period 48
`timescale 1ns/10ps
`include "output_compare_cfg.svh"
module output_compare_pwm_unit_tb_top;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
	note_t notes[$];
	note_t nt;
	logic clk, rst, psel, penable, pwrite, roll_a, roll_b, idle, fault_n, pin, pready, pslverr;
	logic [`OC_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] cnt_a, cnt_b, hi_a, hi_b, vh;
	logic [5:0] pat [8] = '{6'h00, 6'h1f, 6'h20, 6'h1c, 6'h10, 6'h12, 6'h06, 6'h06};
	int err_count, check_count, rises;
	integer seed;
	assign roll_a = cnt_a == 16'h0;
	assign roll_b = cnt_b == 16'h0;
	output_compare_pwm_unit output_compare_pwm_unit_inst (.REF_CLK(clk), .RESET(rst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIMEBASE_A_COUNT({hi_a, cnt_a}),
		.TIMEBASE_B_COUNT({hi_b, cnt_b}), .TIMEBASE_A_ROLL(roll_a), .TIMEBASE_B_ROLL(roll_b),
		.IDLE_MODE(idle), .FAULT_N(fault_n), .COMPARE_OUTPUT_PIN(pin));
	pin_load pin_load_inst (.clk(clk), .pin(pin), .rises(rises));
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cnt_a <= cnt_a == 16'd39 ? 16'h0 : cnt_a + 16'h1;
		cnt_b <= cnt_b == 16'd47 ? 16'h0 : cnt_b + 16'h1;
	end
////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [`OC_ADDR_W-1:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic se);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		notes.push_back('{e, w ? 32'h0 : 32'hffff_ffff, se});
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [`OC_ADDR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [`OC_ADDR_W-1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, e, 1'b0);
	endtask
	task automatic at(input logic b, input logic [15:0] k);
		@(posedge clk);
		while ((b ? cnt_b : cnt_a) !== k) @(posedge clk);
	endtask
	// pin is sampled at counts 8, 25 and 35 of two periods; events sit at 20 and 30
	task automatic run(input logic [31:0] c, input logic [15:0] v, input logic idl,
		input logic [5:0] p);
		int r0;
		int n;
		wr(`OC_PRIMARY_OFS, {v, 16'd20});
		wr(`OC_SECONDARY_OFS, {v, 16'd30});
		at(c[3], 16'd0);
		wr(`OC_CTRL_OFS, c);
		n = 0;
		r0 = 0;
		for (int i = 0; i < 6; i++) begin
			at(c[3], i % 3 == 0 ? 16'd8 : (i % 3 == 1 ? 16'd25 : 16'd35));
			if (i == 0) begin
				r0 = rises;
				idle <= idl;
			end else if (!p[6-i] && p[5-i]) begin
				n++;
			end
			chk("pin", {31'h0, p[5-i]}, {31'h0, pin});
		end
		chk("rises", n, rises - r0);
		idle <= 1'b0;
	endtask
////////////////////////////////////////
	always @(posedge clk) begin
		if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1) begin
			if (notes.size() == 0) begin
				chk("note", 32'h0, 32'h1);
			end else begin
				nt = notes.pop_front();
				chk("prdata", nt.d, prdata & nt.m);
				chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test();
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		idle = 1'b0;
		fault_n = 1'b1;
		cnt_a = 16'h0;
		cnt_b = 16'h0;
		seed = 32'hbd9d;
		hi_a = 16'($random(seed));
		hi_b = 16'($random(seed));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(`OC_CTRL_OFS, 32'h0);
		wr(`OC_CTRL_OFS, 32'hffff_ffff);
		rd(`OC_CTRL_OFS, 32'h0000_a02f);
		bus(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
		bus(1'b1, 12'hffc, 32'hffff_ffff, 32'h0, 1'b1);
		for (int k = 0; k < 32; k++) begin
			vh = k[4] ? (k[3] ? hi_b : hi_a) : 16'($random(seed));
			run({16'h0, 1'b1, 9'h0, k[4], 1'b0, k[3], k[2:0]}, vh, 1'b0, pat[k[2:0]]);
		end
		run(32'h0000_0001, hi_a, 1'b0, 6'h00);
		run(32'h0000_8021, ~hi_a, 1'b0, 6'h00);
		rd(`OC_PRIMARY_OFS, {~hi_a, 16'd20});
		run(32'h0000_a003, hi_a, 1'b1, 6'h00);
		run(32'h0000_8001, hi_a, 1'b1, 6'h1f);
		fault_n <= 1'b0;
		run(32'h0000_8007, hi_a, 1'b0, 6'h00);
		rd(`OC_CTRL_OFS, 32'h0000_8017);
		fault_n <= 1'b1;
		wr(`OC_PRIMARY_OFS, 32'h0);
		rd(`OC_CTRL_OFS, 32'h0000_8017);
		fault_n <= 1'b0;
		run(32'h0000_8006, hi_a, 1'b0, 6'h06);
		rd(`OC_CTRL_OFS, 32'h0000_8006);
		finish_test();
	end
endmodule
